//--- eeprom_cache_map.vh
// constants for the page cache write path of the serial memory
`ifndef EEPROM_CACHE_MAP_VH
`define EEPROM_CACHE_MAP_VH
// device type code expected in the top four bits of the control byte
`define CTRL_TYPE 4'ha
// cache shape: pages of bytes
`define PAGE_BYTES 8
`define CACHE_PAGES 8
`define CACHE_BYTES 64
// input buffer between the shifter and the cache
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
// self-timed page programming time, longest, in ms
`define T_PAGE_MS 5
// system clock rate in kHz
`define MCLK_KHZ 10000
// cycles per page write, the exact product of the longest time and the clock rate
`define PAGE_CYCLES (`T_PAGE_MS * `MCLK_KHZ)
`endif

//--- eeprom_cache_write.v
// serial memory write path: bus slave, input fifo, page cache and commit sequencer
`include "eeprom_cache_map.vh"

////////////////////////////////////////////////////////////////////////////////
// simple synchronous fifo, flip-flop storage addressed by index
module byte_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // storage words
  reg [AW:0] wr_ptr_r; // write pointer with wrap bit
  reg [AW:0] rd_ptr_r; // read pointer with wrap bit
  wire push; // word accepted
  wire pop; // word taken
  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointer update
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
  // storage write, no reset needed on data
  always @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1 - sixty-four byte cache, eight pages of eight
// RULE2 - accept data until stop, stop starts programming
// RULE3 - each loaded page costs one full page time
// RULE4 - overflow wraps pointer to cache page zero
// RULE5 - ignore all commands while programming
// RULE6 - aligned start programs consecutive pages across blocks
// RULE7 - commit pages one by one, carrying rows
// RULE8 - first byte lands in page zero at low bits
// RULE9 - non-aligned overflow fills leading slots of page zero
// RULE10 - only loaded bytes of a page are written
// RULE11 - standby after stop and idle, or bus error
// RULE12 - low supply blocks writes, monitor off in standby
// RULE13 - answer only when select bits match pins
// RULE14 - data line is open drain, low or released
// RULE15 - data changes with clock high mean start/stop
// RULE16 - serial clock is an input from the master
// RULE17 - withhold control byte acknowledge while busy
// RULE18 - protected pages skipped silently, no abort
// RULE19 - commit from page zero upward, skip empty pages
module eeprom_cache_write #(
  parameter PAGE_CYC = `PAGE_CYCLES
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // two-wire bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n,
  // device select pins
  input wire select_pin_low,
  input wire select_pin_mid,
  input wire select_pin_high,
  // protection window and supply monitor
  input wire [3:0] prot_start,
  input wire [3:0] prot_count,
  input wire vdd_low,
  output wire vdd_mon_en,
  // array page write port
  output reg arr_we_r,
  output reg [9:0] arr_page_r,
  output reg [63:0] arr_data_r,
  output reg [7:0] arr_mask_r,
  // status
  output wire busy,
  output reg standby_r
);
  // bus phases, one-hot
  localparam P_IDLE = 6'h01;
  localparam P_CTRL = 6'h02;
  localparam P_AHI = 6'h04;
  localparam P_ALO = 6'h08;
  localparam P_DATA = 6'h10;
  localparam P_SKIP = 6'h20;
  // write engine states, one-hot
  localparam S_LOAD = 3'h1;
  localparam S_PROG = 3'h2;
  localparam S_WAIT = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [2:0] scl_sh_r; // two sync stages plus history
  reg [2:0] sda_sh_r; // two sync stages plus history
  reg [2:0] sel_s1_r; // select pins first stage
  reg [2:0] sel_s2_r; // select pins second stage
  wire scl_rise; // sampled clock rising
  wire scl_fall; // sampled clock falling
  wire start_det; // data falls while clock high
  wire stop_det; // data rises while clock high
  // sample clock and data as plain inputs [RULE16]
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sh_r <= 3'h7;
      sda_sh_r <= 3'h7;
      sel_s1_r <= 3'h0;
      sel_s2_r <= 3'h0;
    end else begin
      scl_sh_r <= {scl_sh_r[1:0], scl_i};
      sda_sh_r <= {sda_sh_r[1:0], sda_i};
      sel_s1_r <= {select_pin_high, select_pin_mid, select_pin_low};
      sel_s2_r <= sel_s1_r;
    end
  end
  assign scl_rise = scl_sh_r[1] && !scl_sh_r[2];
  assign scl_fall = !scl_sh_r[1] && scl_sh_r[2];
  // data edges with clock held high are framing, not bits [RULE15]
  assign start_det = scl_sh_r[1] && scl_sh_r[2] && !sda_sh_r[1] && sda_sh_r[2];
  assign stop_det = scl_sh_r[1] && scl_sh_r[2] && sda_sh_r[1] && !sda_sh_r[2];

  //////////////////////////////////////////////////////////////////////////////
  // byte receiver and acknowledge
  reg [5:0] phase_r; // bus phase
  reg [3:0] bit_cnt_r; // bits received in this byte
  reg [7:0] shift_r; // incoming byte
  reg ack_r; // pulling data low for acknowledge
  reg in_ack_r; // inside the acknowledge clock
  reg [4:0] addr_hi_r; // upper word address bits
  reg [2:0] state_r; // write engine state
  reg fifo_push_r; // one-cycle push of a data byte
  reg [7:0] fifo_din_r; // byte pushed
  reg first_r; // next data byte is the first
  reg [2:0] start_off_r; // offset of the first byte
  reg [9:0] start_page_r; // array page of cache page zero
  reg commit_pend_r; // stop seen, waiting for fifo to drain
  wire fifo_in_ready; // fifo has room
  wire [7:0] rx_byte; // byte as it completes
  assign rx_byte = shift_r;
  assign busy = (state_r != S_LOAD);
  // open drain: value always low, enable only while acknowledging [RULE14]
  assign sda_o = 1'b0;
  assign sda_oe_n = !ack_r;

  // receiver sequence
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= P_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
      in_ack_r <= 1'b0;
      addr_hi_r <= 5'h00;
      fifo_push_r <= 1'b0;
      fifo_din_r <= 8'h00;
      first_r <= 1'b0;
      start_off_r <= 3'h0;
      start_page_r <= 10'h000;
    end else begin
      fifo_push_r <= 1'b0;
      if (start_det) begin
        // new frame, ignored entirely while programming [RULE5]
        phase_r <= busy ? P_SKIP : P_CTRL;
        bit_cnt_r <= 4'h0;
        ack_r <= 1'b0;
        in_ack_r <= 1'b0;
      end else if (stop_det) begin
        phase_r <= P_IDLE;
        ack_r <= 1'b0;
        in_ack_r <= 1'b0;
      end else if (scl_rise && !in_ack_r && bit_cnt_r != 4'h8) begin
        // shift data on the rising clock edge [RULE16]
        shift_r <= {shift_r[6:0], sda_sh_r[1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && in_ack_r) begin
        // acknowledge clock over; without one, drop out of the frame [RULE11]
        ack_r <= 1'b0;
        in_ack_r <= 1'b0;
        bit_cnt_r <= 4'h0;
        if (!ack_r) begin
          phase_r <= P_SKIP;
        end
      end else if (scl_fall && bit_cnt_r == 4'h8) begin
        in_ack_r <= 1'b1;
        case (phase_r)
          P_CTRL: begin
            // type and select bits must match, and not busy [RULE13] [RULE17]
            if (rx_byte[7:4] == `CTRL_TYPE && rx_byte[3:1] == sel_s2_r && !busy) begin
              ack_r <= 1'b1;
              // reads are not served by this path
              phase_r <= rx_byte[0] ? P_SKIP : P_AHI;
            end
          end
          P_AHI: begin
            ack_r <= 1'b1;
            addr_hi_r <= rx_byte[4:0];
            phase_r <= P_ALO;
          end
          P_ALO: begin
            ack_r <= 1'b1;
            start_off_r <= rx_byte[2:0];
            start_page_r <= {addr_hi_r, rx_byte[7:3]};
            first_r <= 1'b1;
            phase_r <= P_DATA;
          end
          P_DATA: begin
            // keep taking bytes until stop; a full fifo refuses [RULE2]
            if (fifo_in_ready) begin
              ack_r <= 1'b1;
              fifo_push_r <= 1'b1;
              fifo_din_r <= rx_byte;
            end
          end
          default: begin
            ack_r <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input fifo between shifter and cache
  wire fifo_out_valid; // byte waiting for the cache
  wire [7:0] fifo_dout; // byte to the cache
  wire cache_take; // cache writes a byte this cycle
  assign cache_take = fifo_out_valid && (state_r == S_LOAD);
  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(fifo_push_r),
    .in_ready(fifo_in_ready),
    .in_data(fifo_din_r),
    .out_valid(fifo_out_valid),
    .out_ready(state_r == S_LOAD),
    .out_data(fifo_dout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // page cache and commit sequencer
  reg [7:0] cache_r [0:`CACHE_BYTES-1]; // eight pages of eight bytes [RULE1]
  reg [63:0] loaded_r; // byte has received data
  reg [5:0] load_ptr_r; // next cache slot
  reg [3:0] pg_idx_r; // cache page being committed
  reg [15:0] timer_r; // page write timer
  reg first_seen_r; // first byte of the frame consumed
  wire [7:0] page_used; // page holds at least one byte
  wire [63:0] page_data; // bytes of the current page
  wire [7:0] page_mask; // loaded bytes of the current page
  wire [9:0] tgt_page; // array page for the current cache page
  wire [4:0] blk_rel; // block distance from protection start
  wire prot_hit; // current target protected
  // per page occupancy and current page bytes
  genvar g;
  generate
    for (g = 0; g < `CACHE_PAGES; g = g + 1) begin : g_page
      localparam [2:0] BYTE_POS = g; // byte position within a page
      assign page_used[g] = |loaded_r[g*8 +: 8];
      assign page_data[g*8 +: 8] = cache_r[{pg_idx_r[2:0], BYTE_POS}];
    end
  endgenerate
  assign page_mask = loaded_r[pg_idx_r[2:0]*8 +: 8];
  // successive pages, carrying across rows and blocks [RULE6] [RULE7] [RULE9]
  assign tgt_page = start_page_r + {7'h00, pg_idx_r[2:0]};
  assign blk_rel = {1'b0, tgt_page[9:6]} - {1'b0, prot_start};
  assign prot_hit = (tgt_page[9:6] >= prot_start) && (blk_rel < {1'b0, prot_count});

  // cache load and page commit engine
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_LOAD;
      loaded_r <= 64'h0;
      load_ptr_r <= 6'h00;
      pg_idx_r <= 4'h0;
      timer_r <= 16'h0000;
      commit_pend_r <= 1'b0;
      first_seen_r <= 1'b0;
      arr_we_r <= 1'b0;
      arr_page_r <= 10'h000;
      arr_data_r <= 64'h0;
      arr_mask_r <= 8'h00;
    end else begin
      arr_we_r <= 1'b0;
      if (start_det && !busy) begin
        first_seen_r <= 1'b0;
      end
      case (state_r)
        S_LOAD: begin
          if (cache_take) begin
            // first byte goes to page zero at the low address bits [RULE8]
            // pointer wraps to page zero and overwrites [RULE4] [RULE9]
            if (!first_seen_r) begin
              cache_r[{3'h0, start_off_r}] <= fifo_dout;
              loaded_r[{3'h0, start_off_r}] <= 1'b1;
              load_ptr_r <= {3'h0, start_off_r} + 6'h01;
              first_seen_r <= 1'b1;
            end else begin
              cache_r[load_ptr_r] <= fifo_dout;
              loaded_r[load_ptr_r] <= 1'b1;
              load_ptr_r <= load_ptr_r + 6'h01;
            end
          end else if (commit_pend_r && !fifo_out_valid) begin
            // stop with data drained starts programming [RULE2]
            commit_pend_r <= 1'b0;
            pg_idx_r <= 4'h0;
            state_r <= S_PROG;
          end
        end
        S_PROG: begin
          if (pg_idx_r == 4'h8) begin
            // all pages done, empty the cache
            loaded_r <= 64'h0;
            first_seen_r <= 1'b0;
            state_r <= S_LOAD;
          end else if (!page_used[pg_idx_r[2:0]]) begin
            // empty pages cost one cycle each, no page time [RULE19]
            pg_idx_r <= pg_idx_r + 4'h1;
          end else begin
            // loaded bytes only; protected or low supply writes nothing [RULE10] [RULE12] [RULE18]
            arr_we_r <= !prot_hit && !vdd_low;
            arr_page_r <= tgt_page;
            arr_data_r <= page_data;
            arr_mask_r <= page_mask;
            timer_r <= PAGE_CYC[15:0] - 16'h0001;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          // full page time even for a partial page [RULE3]
          if (timer_r == 16'h0000) begin
            pg_idx_r <= pg_idx_r + 4'h1;
            state_r <= S_PROG;
          end else begin
            timer_r <= timer_r - 16'h0001;
          end
        end
        default: begin
          state_r <= S_LOAD;
        end
      endcase
      // stop of a write frame marks work pending; set wins over a clear
      if (stop_det && phase_r == P_DATA) begin
        commit_pend_r <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // standby tracking
  // standby once idle on the bus with no work pending [RULE11]
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= (phase_r == P_IDLE || phase_r == P_SKIP) && !busy && !commit_pend_r
                   && !fifo_out_valid;
    end
  end
  // supply monitor runs only out of standby [RULE12]
  assign vdd_mon_en = !standby_r;
endmodule

//--- cache_write_asserts.sv
// checker on the ports of the cache write path
module cache_write_asserts #(
  parameter PAGE_CYC = 20
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // bus data pin
  input wire sda_o,
  input wire sda_oe_n,
  // supply monitor
  input wire vdd_low,
  input wire vdd_mon_en,
  // array port and status
  input wire arr_we_r,
  input wire [9:0] arr_page_r,
  input wire [7:0] arr_mask_r,
  input wire busy,
  input wire standby_r
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_r; // cycles since the last page write
  logic seen_r; // a page write happened in this busy period

  ////////////////////////////////////////////////////////////////////////////
  // helper: spacing of page writes within one programming run
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= arr_we_r ? 1 : gap_r + 1;
      seen_r <= arr_we_r | (seen_r & busy);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // one page write is a single-cycle strobe
  sequence s_pulse;
    arr_we_r ##1 !arr_we_r;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_pulse_single: assert property (arr_we_r |-> s_pulse)
    else $error("page write strobe longer than one cycle");
  a_write_busy: assert property (arr_we_r |-> busy)
    else $error("page write outside programming");
  a_gap_page: assert property (arr_we_r && seen_r |-> gap_r >= PAGE_CYC && gap_r <= PAGE_CYC + 2)
    else $error("page write spacing wrong");
  a_page_next: assert property (arr_we_r && seen_r |-> arr_page_r == $past(arr_page_r) + 10'h1)
    else $error("array page not consecutive");
  a_mask_loaded: assert property (arr_we_r |-> arr_mask_r != 8'h00)
    else $error("empty page written");
  a_busy_min: assert property ($rose(busy) |-> busy[*8])
    else $error("programming too short");
  a_standby_busy: assert property (busy |-> !standby_r)
    else $error("standby while programming");
  a_monitor_off: assert property (standby_r |-> !vdd_mon_en)
    else $error("supply monitor on in standby");
  a_low_block: assert property (vdd_low[*3] |-> !arr_we_r)
    else $error("page write at low supply");
  a_drain_only: assert property (!sda_oe_n |-> sda_o == 1'b0)
    else $error("data pin driven high");
  a_quiet_busy: assert property (busy[*4] |-> sda_oe_n)
    else $error("acknowledge while programming");
endmodule

//--- bus_master.sv
// two-wire bus master model: start, stop and byte transfers
module bus_master (
  // clock
  input wire mclk,
  // resolved data line level
  input wire sda_line,
  // driven pins, data released when high
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idles released, clock only from this side
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // start: data falls while clock high
  task automatic start_c();
    sda_m <= 1'b0;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask

  // stop: data rises while clock high, clock then stands still
  task automatic stop_c();
    sda_m <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(2);
    sda_m <= 1'b1;
    wt(6);
  endtask

  // one bit of 800 ns: data moves only while clock low
  task automatic bit_c(input logic b, output logic s);
    sda_m <= b;
    wt(2);
    scl <= 1'b1;
    wt(3);
    s = sda_line;
    wt(1);
    scl <= 1'b0;
    wt(2);
  endtask

  // byte msb first, then a released ninth bit for the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask
endmodule

//--- testbench.sv
// testbench for the cache write path
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 120; // shortened page time
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] sel = 3'b101; // select straps
  logic [3:0] prot_start = 4'h0;
  logic [3:0] prot_count = 4'h0;
  logic vdd_low = 1'b0;
  wire scl, sda_m, sda_line, sda_o, sda_oe_n, vdd_mon_en, busy, standby_r, arr_we_r;
  wire [9:0] arr_page_r;
  wire [63:0] arr_data_r;
  wire [7:0] arr_mask_r;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [9:0] cap_pg[$]; // captured page writes
  logic [63:0] cap_dt[$];
  logic [7:0] cap_mk[$];
  logic [7:0] cache[64]; // cache model
  logic [63:0] mask;

  // open drain line with pull-up
  assign sda_line = sda_m & (sda_oe_n | sda_o);

  always #50 mclk = ~mclk;

  eeprom_cache_write #(.PAGE_CYC(PC)) eeprom_cache_write_inst (
    .mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .select_pin_low(sel[0]), .select_pin_mid(sel[1]),
    .select_pin_high(sel[2]), .prot_start(prot_start), .prot_count(prot_count),
    .vdd_low(vdd_low), .vdd_mon_en(vdd_mon_en), .arr_we_r(arr_we_r),
    .arr_page_r(arr_page_r), .arr_data_r(arr_data_r), .arr_mask_r(arr_mask_r),
    .busy(busy), .standby_r(standby_r)
  );
  bus_master bus_master_inst (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  ////////////////////////////////////////////////////////////////////////////
  // cycle count, hang limit and page write capture
  always @(posedge mclk) begin
    cycles++;
    if (arr_we_r === 1'b1) begin
      cap_pg.push_back(arr_page_r);
      cap_dt.push_back(arr_data_r);
      cap_mk.push_back(arr_mask_r);
    end
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one write frame; data byte k carries k + 17
  task automatic send(input logic [12:0] a, input int n, input logic [2:0] cs, input logic ok);
    logic ack;
    bus_master_inst.start_c();
    bus_master_inst.put_byte({4'ha, cs, 1'b0}, ack);
    check("control ack", ack, ok);
    if (ok && n > 0) begin
      bus_master_inst.put_byte({3'h0, a[12:8]}, ack);
      bus_master_inst.put_byte(a[7:0], ack);
      for (int k = 0; k < n; k++) begin
        bus_master_inst.put_byte(8'(k + 17), ack);
        check("data ack", ack, 1'b1);
      end
    end
    bus_master_inst.stop_c();
  endtask

  // waits out programming, optionally polling, and compares page writes
  task automatic finish_write(input logic [12:0] a, input int n, input logic poll);
    logic [9:0] pg;
    logic [63:0] ed;
    logic [63:0] mm;
    int np;
    int t0;
    np = 0;
    mask = 64'h0;
    for (int k = 0; k < n; k++) begin
      cache[(a[2:0] + k) % 64] = 8'(k + 17);
      mask[(a[2:0] + k) % 64] = 1'b1;
    end
    t0 = cycles;
    while (busy !== 1'b1 && cycles < t0 + 50) @(posedge mclk);
    check("busy", busy, 1'b1);
    check("standby", standby_r, 1'b0);
    check("monitor on", vdd_mon_en, 1'b1);
    t0 = cycles;
    if (poll) send(13'h0, 0, sel, 1'b0);
    while (busy !== 1'b0 && cycles < t0 + 9 * PC + 99) @(posedge mclk);
    for (int i = 0; i < 8; i++) np += (mask[8*i +: 8] != 0);
    // one page time per loaded page, plus one step per cache page and the return
    check("busy time", cycles - t0 >= np * PC && cycles - t0 <= np * PC + 10, 1);
    repeat (3) @(posedge mclk);
    check("standby", standby_r, 1'b1);
    check("monitor", vdd_mon_en, 1'b0);
    for (int i = 0; i < 8; i++) begin
      pg = a[12:3] + 10'(i);
      for (int b = 0; b < 8; b++) begin
        ed[8*b +: 8] = cache[8*i + b];
        mm[8*b +: 8] = {8{mask[8*i + b]}};
      end
      if (mask[8*i +: 8] != 0 && !vdd_low
          && !(pg[9:6] >= prot_start && {1'b0, pg[9:6]} < prot_start + prot_count)) begin
        check("pulses", cap_pg.size() > 0, 1);
        if (cap_pg.size() > 0) begin
          check("page", cap_pg.pop_front(), pg);
          check("mask", cap_mk.pop_front(), mask[8*i +: 8]);
          check("data", cap_dt.pop_front() & mm, ed & mm);
        end
      end
    end
    check("extra", cap_pg.size(), 0);
  endtask

  task automatic run(input logic [12:0] a, input int n, input logic poll);
    send(a, n, sel, 1'b1);
    finish_write(a, n, poll);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // foreign select refused, byte write, command refused while busy, poll
  task automatic t_single();
    send(13'h0123, 1, sel ^ 3'b001, 1'b0);
    repeat (40) @(posedge mclk);
    check("foreign", busy, 1'b0);
    run(13'h0123, 1, 1'b1);
    send(13'h0, 0, sel, 1'b1);
  endtask

  // full aligned cache across a block edge, plain then protected
  task automatic t_aligned();
    run(13'h01e8, 64, 1'b0);
    prot_count <= 4'h1;
    run(13'h01e8, 64, 1'b0);
    prot_count <= 4'h0;
  endtask

  // unaligned full cache, overflow and partial pages
  task automatic t_unaligned();
    run(13'h001a, 64, 1'b0);
    run(13'h0040, 66, 1'b0);
    run(13'h0045, 10, 1'b0);
  endtask

  // low supply blocks all page writes
  task automatic t_lowvdd();
    vdd_low <= 1'b1;
    run(13'h0100, 16, 1'b0);
    vdd_low <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_single();
    t_aligned();
    t_unaligned();
    t_lowvdd();
    report_and_stop();
  end
endmodule

bind eeprom_cache_write cache_write_asserts #(.PAGE_CYC(PAGE_CYC)) cache_write_asserts_inst (
  .mclk(mclk), .arst_n(arst_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .vdd_low(vdd_low),
  .vdd_mon_en(vdd_mon_en), .arr_we_r(arr_we_r), .arr_page_r(arr_page_r),
  .arr_mask_r(arr_mask_r), .busy(busy), .standby_r(standby_r)
);
